/* logic/irx_pkg.sv */
// package for the receiver event and control register group
// assumes a byte-wide host port with an 8-bit address and a device clock
package irx_pkg;
	localparam logic [7:0] ADDR_EVENT_ACK = 8'h4c;
	localparam logic [7:0] ADDR_EVENT_EN = 8'h50;
	localparam logic [7:0] ADDR_RECEIVE_CHANNEL_NUMBER_CTL = 8'h54;
	localparam int EVENT_BITS = 11;
	localparam logic [10:0] EVENT_EN_RESET = 11'h000;
	localparam logic [10:0] LVL_HUNDRED_LEFT = 11'h39c;
	localparam logic [10:0] LVL_QUARTER_LEFT = 11'h300;
	localparam logic [10:0] LVL_HALF = 11'h200;
	localparam logic [10:0] LVL_FULL = 11'h400;
	localparam int BIT_HUNDRED = 10;
	localparam int BIT_QUARTER = 9;
	localparam int BIT_HALF = 8;
	localparam int BIT_FULL = 7;
	localparam int BIT_EMPTY = 6;
	localparam int BIT_FSYNC = 5;
	localparam int BIT_ORDER = 4;
	localparam int BIT_CHECK = 3;
	localparam int BIT_TAG = 2;
	localparam int BIT_DONE = 1;
	localparam int BIT_STATUS_QUEUE_OVERRUN = 0;
	localparam int RATE_LSB = 16;
	localparam int TAG_LSB = 14;
	localparam int RECEIVE_CHANNEL_NUMBER_LSB = 8;
	localparam int RESULT_LSB = 4;
	localparam int SYNC_LSB = 28;
	localparam logic [3:0] RESULT_OK = 4'h1;
	localparam logic [3:0] RESULT_DATA_ERR = 4'hd;
	localparam logic [1:0] TAG_RESET = 2'h0;
	localparam logic [5:0] RECEIVE_CHANNEL_NUMBER_RESET = 6'h00;
	// one received packet as reported by the datapath
	typedef struct packed {
		logic done;
		logic [5:0] receive_channel_number;
		logic [1:0] tag;
		logic [1:0] rate;
		logic [3:0] sync;
		logic has_data;
		logic data_bad;
		logic crc_bad;
		logic hdr_bad;
	} irx_pkt_t;
	// host register access
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [1:0] lane;
		logic [7:0] wdata;
	} irx_host_t;
endpackage

/* logic/irx_regs.sv */
// receiver event, event enable and channel control registers
// host side writes one byte lane per cycle; datapath status synchronous to CLK_SYS
// Notes on behaviour
// - bit 10 set at 924 quadlets
// - bit 9 set at 768 quadlets
// - bit 8 set at 512 quadlets
// - bit 7 set when buffer becomes full
// - bit 6 set when buffer becomes empty
// - bit 5 set on frame-sync pulse
// - bit 4 set on block sequence gap
// - bit 3 set on packet CRC failure
// - bad header tag drops packet, bit 2
// - bit 1 set per finished packet matching the programmed channel and tag
// - bit 0 set on status queue overrun
// - eleven enables, all clear after reset
// - last packet rate at bits 17..16
// - accept only packets matching tag field
// - receive only on programmed channel
// - result code of last packet, bits 7..4
// - code 0001 means accepted
// - 1101 data error, only with payload
// - sync code held at bits 31..28
// - sync bit 1 drives key pin
module irx_regs (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_N,
	// host register port
	input wire irx_pkg::irx_host_t HOST,
	output logic [7:0] HOST_RDATA,
	// receive datapath status
	input wire logic [10:0] FILL_LEVEL,
	input wire logic FSYNC_PULSE,
	input wire logic SEQ_GAP,
	input wire logic STATUS_OVERRUN,
	input wire irx_pkg::irx_pkt_t PKT,
	input wire logic APP_PKT_OUT,
	// results
	output logic PKT_ACCEPT,
	output logic PORT_KEY_SELECT_PIN,
	output logic IRQ
);
	import irx_pkg::*;

	logic rst_s1_r, rst_s2_r;
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end
	wire rst_n = rst_s2_r;

	logic [10:0] event_r, event_nxt, enable_r;
	logic [1:0] tag_r, rate_r;
	logic [5:0] receive_channel_number_r;
	logic [3:0] result_r, sync_r;
	logic [10:0] fill_prev_r;
	logic accept_r, key_r, irq_r, seen_pkt_r;
	logic [7:0] rdata_r;

	// level crossing detection on the fill count
	wire rise_hundred = FILL_LEVEL >= LVL_HUNDRED_LEFT && fill_prev_r < LVL_HUNDRED_LEFT;
	wire rise_quarter = FILL_LEVEL >= LVL_QUARTER_LEFT && fill_prev_r < LVL_QUARTER_LEFT;
	wire rise_half = FILL_LEVEL >= LVL_HALF && fill_prev_r < LVL_HALF;
	wire rise_full = FILL_LEVEL == LVL_FULL && fill_prev_r != LVL_FULL;
	wire fall_empty = FILL_LEVEL == 11'h000 && fill_prev_r != 11'h000;

	// packet filter on channel and tag
	wire pkt_match = PKT.done && PKT.receive_channel_number == receive_channel_number_r && PKT.tag == tag_r;
	wire pkt_good = pkt_match && !PKT.hdr_bad;

	wire [10:0] ev_set;
	assign ev_set[BIT_HUNDRED] = rise_hundred;
	assign ev_set[BIT_QUARTER] = rise_quarter;
	assign ev_set[BIT_HALF] = rise_half;
	assign ev_set[BIT_FULL] = rise_full;
	assign ev_set[BIT_EMPTY] = fall_empty;
	assign ev_set[BIT_FSYNC] = FSYNC_PULSE;
	assign ev_set[BIT_ORDER] = SEQ_GAP;
	assign ev_set[BIT_CHECK] = pkt_match && PKT.crc_bad;
	assign ev_set[BIT_TAG] = pkt_match && PKT.hdr_bad;
	assign ev_set[BIT_DONE] = pkt_match;
	assign ev_set[BIT_STATUS_QUEUE_OVERRUN] = STATUS_OVERRUN;

	// byte-lane write strobes
	wire wr_ack = HOST.wr && HOST.addr == ADDR_EVENT_ACK;
	wire wr_en = HOST.wr && HOST.addr == ADDR_EVENT_EN;
	wire wr_ctl = HOST.wr && HOST.addr == ADDR_RECEIVE_CHANNEL_NUMBER_CTL;
	wire [31:0] wmask = 32'h0000_00ff << {HOST.lane, 3'b000};
	wire [31:0] wword = {4{HOST.wdata}};
	wire [10:0] ack_clr = wr_ack ? (wword[10:0] & wmask[10:0]) : 11'h000;

	// write-one clears, a new event wins
	assign event_nxt = (event_r & ~ack_clr) | ev_set;

	wire [3:0] pkt_result = (PKT.has_data && (PKT.data_bad || PKT.crc_bad)) ?
		RESULT_DATA_ERR : RESULT_OK;

	// register read mux
	wire [31:0] ctl_word = ({28'h0, sync_r} << SYNC_LSB) | ({30'h0, rate_r} << RATE_LSB) |
		({30'h0, tag_r} << TAG_LSB) | ({26'h0, receive_channel_number_r} << RECEIVE_CHANNEL_NUMBER_LSB) |
		({28'h0, result_r} << RESULT_LSB);
	wire [31:0] rd_word;
	assign rd_word = HOST.addr == ADDR_EVENT_ACK ? {21'h0, event_r} :
		HOST.addr == ADDR_EVENT_EN ? {21'h0, enable_r} :
		HOST.addr == ADDR_RECEIVE_CHANNEL_NUMBER_CTL ? ctl_word : 32'h0;
	wire [7:0] rd_byte = 8'(rd_word >> {HOST.lane, 3'b000});

	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			event_r <= 11'h000;
			fill_prev_r <= 11'h000;
		end else begin
			event_r <= event_nxt;
			fill_prev_r <= FILL_LEVEL;
		end
	end

	// enables clear after reset, written per byte lane
	wire [10:0] enable_wr = (enable_r & ~wmask[10:0]) | (wword[10:0] & wmask[10:0]);
	wire [10:0] enable_nxt = wr_en ? enable_wr : enable_r;
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			enable_r <= EVENT_EN_RESET;
		end else begin
			enable_r <= enable_nxt;
		end
	end

	// writable tag and channel fields, lane 1 only
	wire ctl_lane1 = wr_ctl && HOST.lane == 2'h1;
	wire [1:0] tag_nxt = ctl_lane1 ? HOST.wdata[7:6] : tag_r;
	wire [5:0] receive_channel_number_nxt = ctl_lane1 ? HOST.wdata[5:0] : receive_channel_number_r;
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			tag_r <= TAG_RESET;
			receive_channel_number_r <= RECEIVE_CHANNEL_NUMBER_RESET;
		end else begin
			tag_r <= tag_nxt;
			receive_channel_number_r <= receive_channel_number_nxt;
		end
	end

	wire [1:0] rate_nxt = pkt_good ? PKT.rate : rate_r;
	wire [3:0] result_nxt = pkt_good ? pkt_result : result_r;
	wire [3:0] sync_nxt = pkt_good ? PKT.sync : sync_r;
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			rate_r <= 2'h0;
			result_r <= 4'h0;
			sync_r <= 4'h0;
		end else begin
			rate_r <= rate_nxt;
			result_r <= result_nxt;
			sync_r <= sync_nxt;
		end
	end

	// marks that a packet has updated the status fields
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			seen_pkt_r <= 1'b0;
		end else begin
			seen_pkt_r <= seen_pkt_r | pkt_good;
		end
	end

	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			accept_r <= 1'b0;
			key_r <= 1'b0;
			irq_r <= 1'b0;
			rdata_r <= 8'h00;
		end else begin
			accept_r <= pkt_good;
			// key select while packet is output
			key_r <= APP_PKT_OUT & sync_r[1];
			irq_r <= |(event_nxt & enable_nxt);
			rdata_r <= HOST.rd ? rd_byte : rdata_r;
		end
	end

	assign HOST_RDATA = rdata_r;
	assign PKT_ACCEPT = accept_r;
	assign PORT_KEY_SELECT_PIN = key_r;
	assign IRQ = irq_r;

	a_full_event: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		(FILL_LEVEL == LVL_FULL && fill_prev_r != LVL_FULL) |=> event_r[BIT_FULL])
		else $error("full event not latched");
	a_hundred_event: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		$rose(FILL_LEVEL >= LVL_HUNDRED_LEFT) |=> event_r[BIT_HUNDRED])
		else $error("hundred-left event not latched");
	a_fsync_event: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		FSYNC_PULSE |=> event_r[BIT_FSYNC])
		else $error("frame sync event missing");
	a_ack_clear: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		(wr_ack && ack_clr[BIT_DONE] && !ev_set[BIT_DONE]) |=> !event_r[BIT_DONE])
		else $error("acknowledge did not clear");
	a_irq_gate: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		IRQ == |(event_r & enable_r))
		else $error("irq does not follow enabled events");
	a_tag_drop: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		(PKT.done && PKT.hdr_bad) |=> !PKT_ACCEPT)
		else $error("faulty header accepted");
	a_receive_channel_number_filter: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		(PKT.done && PKT.receive_channel_number != receive_channel_number_r) |=> !PKT_ACCEPT && $stable(result_r))
		else $error("foreign channel taken");
	a_result_code: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		(pkt_good && !PKT.has_data) |=> result_r == RESULT_OK)
		else $error("data error without payload");
	a_key_pin: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		(APP_PKT_OUT && sync_r[1]) ##1 $stable(sync_r) |-> PORT_KEY_SELECT_PIN)
		else $error("key pin not driven");

	// fill level and datapath events
	a_quarter_event: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		$rose(FILL_LEVEL >= LVL_QUARTER_LEFT) |=> event_r[BIT_QUARTER])
		else $error("quarter-left event not latched");
	a_half_event: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		$rose(FILL_LEVEL >= LVL_HALF) |=> event_r[BIT_HALF])
		else $error("half event not latched");
	a_empty_event: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		$fell(FILL_LEVEL != 11'h000) |=> event_r[BIT_EMPTY])
		else $error("empty event not latched");
	a_order_event: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		SEQ_GAP |=> event_r[BIT_ORDER])
		else $error("sequence gap event missing");
	a_overrun_event: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		STATUS_OVERRUN |=> event_r[BIT_STATUS_QUEUE_OVERRUN])
		else $error("overrun event missing");

	// packet events and acknowledge
	a_check_event: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		(pkt_match && PKT.crc_bad) |=> event_r[BIT_CHECK])
		else $error("crc event missing");
	a_done_event: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		pkt_match |=> event_r[BIT_DONE])
		else $error("packet done event missing");
	a_event_hold: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		!wr_ack |=> (event_r & $past(event_r)) == $past(event_r))
		else $error("event lost without acknowledge");
	a_set_wins: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		(wr_ack && ack_clr[BIT_DONE] && ev_set[BIT_DONE]) |=> event_r[BIT_DONE])
		else $error("clear beat a new event");

	// enable and control writes
	a_enable_low: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		(wr_en && HOST.lane == 2'h0) |=> enable_r[7:0] == $past(HOST.wdata))
		else $error("low enable byte not written");
	a_enable_high: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		(wr_en && HOST.lane == 2'h1) |=> enable_r[10:8] == $past(HOST.wdata[2:0]))
		else $error("high enable bits not written");
	a_receive_channel_number_write: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		(wr_ctl && HOST.lane == 2'h1) |=> receive_channel_number_r == $past(HOST.wdata[5:0]) &&
		tag_r == $past(HOST.wdata[7:6]))
		else $error("channel and tag not written");

	// status of received packets
	a_rate_capture: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		pkt_good |=> rate_r == $past(PKT.rate))
		else $error("rate not captured");
	a_sync_capture: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		pkt_good |=> sync_r == $past(PKT.sync))
		else $error("sync code not captured");
	a_tag_filter: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		(PKT.done && PKT.tag != tag_r) |=> !PKT_ACCEPT && $stable(sync_r))
		else $error("foreign tag taken");
	a_result_legal: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		result_r == RESULT_OK || result_r == RESULT_DATA_ERR || !seen_pkt_r)
		else $error("reserved result code");
	a_result_ok: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		(pkt_good && !PKT.data_bad && !PKT.crc_bad) |=> result_r == RESULT_OK)
		else $error("clean packet not reported ok");
	a_result_data: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		(pkt_good && PKT.has_data && PKT.data_bad) |=> result_r == RESULT_DATA_ERR)
		else $error("payload error not reported");
	a_status_idle: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		!seen_pkt_r |-> rate_r == 2'h0 && result_r == 4'h0 && sync_r == 4'h0)
		else $error("status set before first packet");
	a_accept_pulse: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		PKT_ACCEPT |-> $past(PKT.done && !PKT.hdr_bad))
		else $error("accept without good packet");
	a_key_low: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		!APP_PKT_OUT |=> !PORT_KEY_SELECT_PIN)
		else $error("key pin driven while idle");
	a_key_follow: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		(APP_PKT_OUT && !sync_r[1]) |=> !PORT_KEY_SELECT_PIN)
		else $error("key pin does not follow sync bit");
endmodule // irx_regs

/* tb/irx_testbench.sv */
// self-checking bench for the receiver event and control registers
// drives host port and datapath status itself at the falling clock edge
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import irx_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	irx_host_t host = '0;
	irx_pkt_t pkt = '0;
	logic [10:0] fill = '0;
	logic fsync = 1'b0, gap = 1'b0, ovr = 1'b0, app = 1'b0;
	logic [7:0] rdata;
	logic accept, key, irq;
	int num_errors = 0, total_checks = 0, cyc = 0;
	logic [31:0] w, st;
	logic [10:0] en;
	logic [5:0] ch;
	logic [1:0] tg;
	logic [10:0] thr [4] = '{LVL_HALF, LVL_QUARTER_LEFT, LVL_HUNDRED_LEFT, LVL_FULL};
	int bt [4] = '{BIT_HALF, BIT_QUARTER, BIT_HUNDRED, BIT_FULL};
	logic match, good;
	always #12.5 clk_sys = ~clk_sys;
	irx_regs irx_regs_i (.CLK_SYS(clk_sys), .RST_N(rst_n), .HOST(host), .HOST_RDATA(rdata),
		.FILL_LEVEL(fill), .FSYNC_PULSE(fsync), .SEQ_GAP(gap), .STATUS_OVERRUN(ovr), .PKT(pkt),
		.APP_PKT_OUT(app), .PKT_ACCEPT(accept), .PORT_KEY_SELECT_PIN(key), .IRQ(irq));
	function automatic logic [3:0] res_of(input irx_pkt_t p);
		return (p.has_data & (p.data_bad | p.crc_bad)) ? RESULT_DATA_ERR : RESULT_OK;
	endfunction
	task automatic finish_test();
		if (num_errors == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick(input int n = 1);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic wr(input logic [7:0] a, input logic [1:0] l, input logic [7:0] d);
		host = '{1'b1, 1'b0, a, l, d};
		tick();
		host.wr = 1'b0;
		tick();
	endtask
	task automatic rd32(input logic [7:0] a, output logic [31:0] v);
		for (int l = 0; l < 4; l++) begin
			host = '{1'b0, 1'b1, a, l[1:0], 8'h00};
			tick();
			host.rd = 1'b0;
			tick();
			v[8 * l +: 8] = rdata;
		end
	endtask
	task automatic clr();
		wr(ADDR_EVENT_ACK, 2'h0, 8'hff);
		wr(ADDR_EVENT_ACK, 2'h1, 8'h07);
	endtask
	// event word read back, request line follows enabled events
	task automatic ev(input logic [10:0] exp);
		rd32(ADDR_EVENT_ACK, w);
		chk(w, {21'h0, exp}, "events");
		chk(irq, |(exp & en), "irq");
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			finish_test();
		end
	end
	initial begin
		void'($urandom(17101));
		tick(16);
		rst_n = 1'b1;
		tick(3);
		// unmapped write must not land anywhere
		wr(8'h58, 2'h0, 8'h5a);
		for (int i = 0; i < 4; i++) begin
			rd32(8'h4c + 8'(4 * i), w);
			chk(w, 32'h0, "reset word");
		end
		en = 11'($urandom);
		wr(ADDR_EVENT_EN, 2'h0, en[7:0]);
		wr(ADDR_EVENT_EN, 2'h1, {5'h1f, en[10:8]});
		rd32(ADDR_EVENT_EN, w);
		chk(w, {21'h0, en}, "enable");
		for (int j = 0; j < 3; j++) begin
			{fsync, gap, ovr} = 3'b100 >> j;
			tick();
			{fsync, gap, ovr} = 3'b000;
			ev(j == 0 ? 11'h020 : j == 1 ? 11'h010 : 11'h001);
			clr();
			tick();
			chk(irq, 1'b0, "irq cleared");
		end
		en = 11'h7ff;
		wr(ADDR_EVENT_EN, 2'h0, 8'hff);
		wr(ADDR_EVENT_EN, 2'h1, 8'h07);
		for (int j = 0; j < 4; j++) begin
			fill = thr[j] - 11'h1;
			tick(2);
			ev(11'h0);
			fill = thr[j];
			tick(2);
			ev(11'h1 << bt[j]);
			clr();
		end
		fill = 11'h0;
		tick(2);
		ev(11'h040);
		clr();
		ch = 6'($urandom);
		tg = 2'h1;
		wr(ADDR_RECEIVE_CHANNEL_NUMBER_CTL, 2'h1, {tg, ch});
		wr(ADDR_RECEIVE_CHANNEL_NUMBER_CTL, 2'h0, 8'hff);
		st = {16'h0, tg, ch, 8'h0};
		for (int j = 0; j < 12; j++) begin
			app = 1'($urandom);
			pkt = irx_pkt_t'(19'($urandom));
			pkt.done = 1'b1;
			pkt.receive_channel_number = (j == 1) ? ~ch : ch;
			pkt.tag = (j == 2) ? ~tg : tg;
			if (pkt.rate == 2'h3) pkt.rate = 2'h2;
			if (j == 0) {pkt.has_data, pkt.crc_bad, pkt.hdr_bad} = 3'b010;
			match = (pkt.receive_channel_number == ch) && (pkt.tag == tg);
			good = match && !pkt.hdr_bad;
			tick();
			pkt.done = 1'b0;
			chk(accept, good, "accept");
			if (good) st = {pkt.sync, 10'h0, pkt.rate, tg, ch, res_of(pkt), 4'h0};
			ev(match ? {7'h0, pkt.crc_bad, pkt.hdr_bad, 2'h2} : 11'h0);
			rd32(ADDR_RECEIVE_CHANNEL_NUMBER_CTL, w);
			chk(w, st, "control");
			chk(key, app & st[29], "key pin");
			clr();
		end
		finish_test();
	end
endmodule // testbench
